// ==== shared/angle_port_pkg.sv ====
// Constants, register map and carriers for the angle output port
package angle_port_pkg;
    // Word geometry
    localparam int FULL_BITS = 22;
    localparam int PHASE_W = 10;
    // Timing, clock at 25 MHz
    localparam int CLK_HZ = 25000000;
    localparam int CLK_PERIOD_PS = 40000;
    localparam int SAMPLE_RATE_HZ = 32768;
    localparam int SAMPLE_CYCLES = (CLK_HZ + SAMPLE_RATE_HZ / 2) / SAMPLE_RATE_HZ;
    localparam int MARKER_WIDTH_PS = 3820000;
    localparam int MARKER_CYCLES =
        (MARKER_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int UPDATE_LEAD_PS = 1910000;
    localparam int UPDATE_LEAD_CYCLES =
        (UPDATE_LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_POSITION = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    // Control fields and reset values
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int CTRL_FLAG_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // Pin synchroniser reset levels: direction and hold idle high
    localparam logic [2:0] PIN_SYNC_RESET = 3'h3;
    // Control register carrier
    typedef struct packed {
        logic flag_in_serial;
        logic serial_model;
    } ctrl_s;
    // Interrupt event carrier, bit 3 first
    typedef struct packed {
        logic test_fail;
        logic serial_done;
        logic hold_granted;
        logic sample_update;
    } irq_events_s;
endpackage : angle_port_pkg

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module pin_sync
    import angle_port_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // One chain per bit; only the second stage is ever read
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    stage1[i] <= RESET_VALUE[i];
                    sync_out[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync

// ==== rtl/serial_word_shifter.sv ====
// Serial interrogation: capture on read, shift out LSB first
`timescale 1ns/10ps
module serial_word_shifter
    import angle_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic read_s,
    input wire logic shift_s,
    input wire logic [FULL_BITS:0] word,
    input wire logic [4:0] total_bits,
    output logic ready,
    output logic serial_data,
    output logic done_pulse
);
    logic read_q;
    logic shift_q;
    logic read_rise;
    logic shift_rise;
    logic [FULL_BITS:0] shreg;
    logic [4:0] sent;

    // Edge history of the synchronised pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_q <= 1'b0;
            shift_q <= 1'b0;
        end else begin
            read_q <= read_s;
            shift_q <= shift_s;
        end
    end

    assign read_rise = enable && read_s && !read_q;
    assign shift_rise = enable && shift_s && !shift_q;

    // A new read always restarts, even mid-word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shreg <= '0;
            sent <= 5'h0;
            ready <= 1'b0;
            serial_data <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (read_rise) begin
                shreg <= word;
                sent <= 5'h0;
                ready <= 1'b1;
                serial_data <= word[0];
            end else if (shift_rise && ready) begin
                shreg <= {1'b0, shreg[FULL_BITS:1]};
                serial_data <= shreg[1];
                sent <= sent + 5'h1;
                if (sent + 5'h1 == total_bits) begin
                    ready <= 1'b0;
                    done_pulse <= 1'b1;
                    serial_data <= 1'b0;
                end
            end else if (!enable) begin
                ready <= 1'b0;
            end
        end
    end

    chk_ready_after_read: assert property (
        @(posedge clk) disable iff (reset)
        read_rise |=> ready && serial_data == $past(word[0]))
        else $error("ready did not follow read");
    chk_lsb_first: assert property (
        @(posedge clk) disable iff (reset)
        (shift_rise && ready && !read_rise && sent + 5'h1 != total_bits)
        |=> serial_data == $past(shreg[1]) && sent == $past(sent) + 5'h1)
        else $error("serial bit order wrong");
    chk_word_stable: assert property (
        @(posedge clk) disable iff (reset)
        (!read_rise && !shift_rise) |=> $stable(shreg))
        else $error("captured word moved");
    chk_word_end: assert property (
        @(posedge clk) disable iff (reset)
        (ready && shift_rise && !read_rise && sent + 5'h1 == total_bits)
        |=> !ready && done_pulse)
        else $error("word did not end after last bit");
endmodule : serial_word_shifter

// ==== rtl/angle_output_port.sv ====
// Position output port: sampling, marker, hold handshake, serial, registers
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

// Overview of operation
// - Binary angle word, MSB is half turn
// - Marker 3.82 us, leads update 1.91 us
// - Hold request low freezes parallel outputs
// - Frozen word is last sample before hold
// - Acknowledge hold at once if marker idle
// - Marker active delays acknowledge until it ends
// - Request release drops acknowledge, resumes updates
// - Serial models drop marker and hold handshake
// - Ready rises once captured word is available
// - Each shift pulse outputs next bit, LSB first
// - Direction pin picks clockwise or counterclockwise count
// - Self-test output low on detected failure
// - Resolution 17 to 22, unused bits zero
// - New sample every 1/32768 second
module angle_output_port
    import angle_port_pkg::*;
#(
    parameter int RESOLUTION = 22
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [FULL_BITS-1:0] raw_angle,
    input wire logic test_fail,
    input wire logic direction_cw,
    input wire logic hold_request_n,
    input wire logic read_request,
    input wire logic serial_shift_clock,
    output logic [FULL_BITS-1:0] position_word,
    output logic update_marker,
    output logic hold_ack,
    output logic ready,
    output logic serial_data,
    output logic self_test_n,
    output logic irq
);
    // Bits below the configured LSB stay at zero
    localparam int DROP = FULL_BITS - RESOLUTION;
    localparam logic [FULL_BITS-1:0] RES_MASK = ~((22'h1 << DROP) - 22'h1);
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SAMPLE_CYCLES - 1);
    localparam logic [PHASE_W-1:0] PHASE_MARKER = PHASE_W'(MARKER_CYCLES);
    localparam logic [PHASE_W-1:0] PHASE_UPDATE = PHASE_W'(UPDATE_LEAD_CYCLES);

    typedef enum {
        HOLD_TRACK,
        HOLD_WAIT,
        HOLD_GRANTED
    } hold_state_e;

    ctrl_s ctrl;
    irq_events_s events;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [3:0] irq_clear;
    logic [2:0] pins_s;
    logic dir_s;
    logic hold_n_s;
    logic read_s;
    logic shift_s;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] next_phase;
    logic [FULL_BITS-1:0] raw_masked;
    logic [FULL_BITS-1:0] oriented;
    logic [FULL_BITS-1:0] sample_reg;
    logic [FULL_BITS:0] serial_word;
    logic [4:0] serial_bits;
    logic test_fail_q;
    logic serial_done;
    logic freeze_entry;
    logic update_ok;
    hold_state_e hold_state;
    hold_state_e next_hold_state;

    // Pins from outside: direction, hold request, serial read
    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE(PIN_SYNC_RESET)
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({read_request, hold_request_n, direction_cw}),
        .sync_out(pins_s)
    );

    // The shift clock is its own synchroniser; the host runs it near 3 MHz
    pin_sync #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) u_clk_sync (
        .clk(clk),
        .reset(reset),
        .async_in(serial_shift_clock),
        .sync_out(shift_s)
    );

    assign dir_s = pins_s[0];
    assign hold_n_s = pins_s[1];
    assign read_s = pins_s[2];

    // Sample period counter
    assign next_phase = (phase == PHASE_LAST) ? '0 : phase + PHASE_W'(1);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= PHASE_LAST;
        end else begin
            phase <= next_phase;
        end
    end

    // Orientation of the count; open direction pin reads high
    assign raw_masked = raw_angle & RES_MASK;
    assign oriented = dir_s ? raw_masked : (~raw_masked + 22'h1) & RES_MASK;

    // Take a new sample at the start of each period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sample_reg <= '0;
        end else if (next_phase == '0) begin
            sample_reg <= oriented;
        end
    end

    // Marker opens each period; absent on serial models
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            update_marker <= 1'b0;
        end else begin
            update_marker <= !ctrl.serial_model && (next_phase < PHASE_MARKER);
        end
    end

    // Hold handshake state
    always_comb begin
        next_hold_state = hold_state;
        case (hold_state)
            HOLD_TRACK: begin
                if (!hold_n_s) begin
                    next_hold_state = update_marker ? HOLD_WAIT : HOLD_GRANTED;
                end
            end
            HOLD_WAIT: begin
                if (hold_n_s) begin
                    next_hold_state = HOLD_TRACK;
                end else if (!update_marker) begin
                    next_hold_state = HOLD_GRANTED;
                end
            end
            HOLD_GRANTED: begin
                if (hold_n_s) begin
                    next_hold_state = HOLD_TRACK;
                end
            end
            default: begin
                next_hold_state = HOLD_TRACK;
            end
        endcase
        if (ctrl.serial_model) begin
            next_hold_state = HOLD_TRACK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_state <= HOLD_TRACK;
            hold_ack <= 1'b0;
        end else begin
            hold_state <= next_hold_state;
            hold_ack <= (next_hold_state == HOLD_GRANTED);
        end
    end

    assign freeze_entry = (hold_state == HOLD_TRACK) && (next_hold_state != HOLD_TRACK);
    assign update_ok = (hold_state == HOLD_TRACK) && (next_hold_state == HOLD_TRACK);

    // Parallel word: updated mid-marker, frozen while held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            position_word <= '0;
        end else if (freeze_entry) begin
            position_word <= sample_reg;
        end else if (update_ok && next_phase == PHASE_UPDATE) begin
            position_word <= sample_reg;
        end
    end

    // Self-test pin is low on failure
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            self_test_n <= 1'b1;
            test_fail_q <= 1'b0;
        end else begin
            self_test_n <= !test_fail;
            test_fail_q <= test_fail;
        end
    end

    // Serial word right aligned, optional flag one place above the angle MSB
    always_comb begin
        serial_word = '0;
        serial_word[RESOLUTION-1:0] = sample_reg[FULL_BITS-1:DROP];
        serial_word[RESOLUTION] = ctrl.flag_in_serial && !test_fail;
        serial_bits = 5'(RESOLUTION) + {4'h0, ctrl.flag_in_serial};
    end

    serial_word_shifter u_shifter (
        .clk(clk),
        .reset(reset),
        .enable(ctrl.serial_model),
        .read_s(read_s),
        .shift_s(shift_s),
        .word(serial_word),
        .total_bits(serial_bits),
        .ready(ready),
        .serial_data(serial_data),
        .done_pulse(serial_done)
    );

    // Interrupt events
    assign events.sample_update = update_ok && next_phase == PHASE_UPDATE;
    assign events.hold_granted = next_hold_state == HOLD_GRANTED && !hold_ack;
    assign events.serial_done = serial_done;
    assign events.test_fail = test_fail && !test_fail_q;
    assign irq_clear = (wr && addr == ADDR_IRQ_STATUS) ? wdata[3:0] : 4'h0;

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_status <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    // Register writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (wr) begin
            if (addr == ADDR_CTRL) begin
                ctrl.serial_model <= wdata[CTRL_SERIAL_BIT];
                ctrl.flag_in_serial <= wdata[CTRL_FLAG_BIT];
            end
            if (addr == ADDR_IRQ_MASK) begin
                irq_mask <= wdata[3:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                ADDR_CTRL: rdata <= {30'h0, ctrl};
                ADDR_STATUS: rdata <= {28'h0, test_fail, ready, hold_ack, update_marker};
                ADDR_POSITION: rdata <= {10'h0, position_word};
                ADDR_IRQ_STATUS: rdata <= {28'h0, irq_status};
                ADDR_IRQ_MASK: rdata <= {28'h0, irq_mask};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    chk_marker_width: assert property (
        @(posedge clk) disable iff (reset)
        $rose(update_marker) && !ctrl.serial_model |-> ##95 update_marker ##1 !update_marker)
        else $error("marker width wrong");
    chk_update_lead: assert property (
        @(posedge clk) disable iff (reset)
        $changed(position_word) && $past(hold_state) == HOLD_TRACK
            && hold_state == HOLD_TRACK && !ctrl.serial_model
        |-> $past(update_marker, 48) && !$past(update_marker, 49))
        else $error("word changed off the marker lead");
    chk_sample_period: assert property (
        @(posedge clk) disable iff (reset)
        phase == PHASE_LAST |=> phase == '0 && sample_reg == $past(oriented))
        else $error("sample period broken");
    chk_hold_freeze: assert property (
        @(posedge clk) disable iff (reset)
        hold_state != HOLD_TRACK && !hold_n_s |=> $stable(position_word))
        else $error("word moved during hold");
    chk_hold_word: assert property (
        @(posedge clk) disable iff (reset)
        freeze_entry |=> position_word == $past(sample_reg))
        else $error("held word is not last sample");
    chk_ack_prompt: assert property (
        @(posedge clk) disable iff (reset)
        hold_state == HOLD_TRACK && !hold_n_s && !update_marker && !ctrl.serial_model
        |=> hold_ack)
        else $error("hold not acknowledged");
    chk_ack_after_marker: assert property (
        @(posedge clk) disable iff (reset)
        $rose(hold_ack) |-> !$past(update_marker) && !$past(hold_n_s))
        else $error("acknowledge during marker");
    chk_ack_release: assert property (
        @(posedge clk) disable iff (reset)
        hold_n_s |=> !hold_ack ##1 hold_state == HOLD_TRACK || !hold_n_s)
        else $error("acknowledge stuck after release");
    chk_serial_quiet: assert property (
        @(posedge clk) disable iff (reset)
        ctrl.serial_model && $past(ctrl.serial_model) |-> !update_marker && !hold_ack)
        else $error("parallel handshake on serial model");
    chk_direction: assert property (
        @(posedge clk) disable iff (reset)
        next_phase == '0 && !dir_s |=> sample_reg == ((~$past(raw_masked) + 22'h1) & RES_MASK))
        else $error("counterclockwise count wrong");
    chk_test_output: assert property (
        @(posedge clk) disable iff (reset)
        test_fail |=> !self_test_n)
        else $error("self-test pin not low on fail");
    chk_unused_bits: assert property (
        @(posedge clk) disable iff (reset)
        (position_word & ~RES_MASK) == '0)
        else $error("unused position bits driven");
endmodule : angle_output_port

// ==== testbench/serial_host_model.sv ====
// Host-side serial reader model: read pulse, ready wait, LSB-first shifting
`timescale 1ns/10ps
module serial_host_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [4:0] nbits,
    input wire logic ready,
    input wire logic serial_data,
    output logic read_request,
    output logic serial_shift_clock,
    output logic busy,
    output logic timed_out,
    output logic [22:0] word
);
    int guard;

    // One interrogation per start; the shift clock rests low between frames
    initial begin
        read_request = 1'b0;
        serial_shift_clock = 1'b0;
        busy = 1'b0;
        timed_out = 1'b0;
        word = '0;
        forever begin
            @(posedge clk);
            if (start === 1'b1) begin
                busy <= 1'b1;
                word <= '0;
                read_request <= 1'b1; // 13 cycles is 520 ns
                repeat (13) @(posedge clk);
                read_request <= 1'b0;
                guard = 0;
                while (ready !== 1'b1 && guard < 200) begin
                    @(posedge clk);
                    guard++;
                end
                timed_out <= (guard >= 200);
                // Bit is taken just before each rise; 320 ns shift period
                for (int i = 0; i < nbits; i++) begin
                    word[i] <= serial_data;
                    serial_shift_clock <= 1'b1;
                    repeat (4) @(posedge clk);
                    serial_shift_clock <= 1'b0;
                    repeat (4) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : serial_host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the angle output port
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
`define WAIT_FOR(c) begin guard = 0; while ((c) !== 1'b1) begin cyc(1); guard++; \
    if (guard > 2000) begin num_errors++; $display("MISMATCH wait exp 1 got 0"); \
    report_and_stop(); end end end
module tb_top
    import angle_port_pkg::*;
;
    localparam int RES = 20;
    localparam logic [21:0] MASK = ~((22'h1 << (FULL_BITS - RES)) - 22'h1);
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [21:0] raw_angle = 22'h0, position_word, old;
    logic test_fail = 1'b0, direction_cw = 1'b1, hold_request_n = 1'b1;
    logic read_request, serial_shift_clock, update_marker, hold_ack, ready;
    logic serial_data, self_test_n, irq, start = 1'b0, busy, timed_out, acked;
    logic [22:0] host_word;
    logic [4:0] nbits = 5'h15;
    int num_errors = 0, n_tests = 0, guard;

    always #20 clk = ~clk;

    angle_output_port #(.RESOLUTION(RES)) dut_u (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .raw_angle(raw_angle),
        .test_fail(test_fail), .direction_cw(direction_cw), .hold_request_n(hold_request_n),
        .read_request(read_request), .serial_shift_clock(serial_shift_clock),
        .position_word(position_word), .update_marker(update_marker), .hold_ack(hold_ack),
        .ready(ready), .serial_data(serial_data), .self_test_n(self_test_n), .irq(irq));

    serial_host_model host_u (.clk(clk), .start(start), .nbits(nbits), .ready(ready),
        .serial_data(serial_data), .read_request(read_request),
        .serial_shift_clock(serial_shift_clock), .busy(busy), .timed_out(timed_out),
        .word(host_word));

    // Sampling point sits just past the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    // Counter-clockwise count is the negated masked angle
    function automatic logic [21:0] exp_pos(input logic [21:0] r, input logic cw);
        logic [21:0] m;
        m = r & MASK;
        return cw ? m : -m;
    endfunction : exp_pos

    task automatic t_regs();
        reg_rd(ADDR_CTRL);
        `CHK("ctrl_reset", 32'h0, d)
        reg_rd(ADDR_IRQ_MASK);
        `CHK("mask_reset", 32'h0, d)
        reg_wr(8'h14, 32'hffffffff);
        reg_rd(8'h14);
        `CHK("unmapped", 32'h0, d)
    endtask : t_regs

    task automatic t_marker(input logic cw, input logic [21:0] r);
        @(posedge clk);
        direction_cw <= cw;
        raw_angle <= r;
        cyc(800);
        `WAIT_FOR(update_marker == 1'b0)
        `WAIT_FOR(update_marker)
        old = position_word;
        cyc(47);
        `CHK("word_before_lead", old, position_word)
        cyc(1);
        `CHK("word_after_lead", exp_pos(r, cw), position_word)
        cyc(47);
        `CHK("marker_high", 1'b1, update_marker)
        cyc(1);
        `CHK("marker_low", 1'b0, update_marker)
        `CHK("word_while_valid", exp_pos(r, cw), position_word)
        `WAIT_FOR(update_marker)
        `CHK("sample_period", 763, 96 + guard)
    endtask : t_marker

    task automatic t_hold(input logic [21:0] r);
        // Start the request with the marker idle so the quick path is taken
        `WAIT_FOR(update_marker == 1'b0)
        old = position_word;
        cyc(10);
        @(posedge clk);
        hold_request_n <= 1'b0;
        raw_angle <= r;
        `WAIT_FOR(hold_ack)
        `CHK("ack_quick", 1'b1, guard <= 4)
        `CHK("held_word", old, position_word)
        cyc(800);
        `CHK("still_held", old, position_word)
        @(posedge clk);
        hold_request_n <= 1'b1;
        `WAIT_FOR(hold_ack == 1'b0)
        `CHK("ack_drop", 1'b1, guard <= 4)
        `WAIT_FOR(update_marker)
        cyc(48);
        `CHK("resumed", exp_pos(r, 1'b1), position_word)
    endtask : t_hold

    task automatic t_hold_marker(input logic [21:0] r);
        @(posedge clk);
        raw_angle <= r;
        cyc(800);
        `WAIT_FOR(update_marker == 1'b0)
        `WAIT_FOR(update_marker)
        @(posedge clk);
        hold_request_n <= 1'b0;
        acked = 1'b0;
        // Acknowledge must wait out the running marker pulse
        for (int i = 0; i < 200 && update_marker === 1'b1; i++) begin
            acked = acked | hold_ack;
            cyc(1);
        end
        `CHK("ack_during_marker", 1'b0, acked)
        `WAIT_FOR(hold_ack)
        `CHK("ack_after_marker", 1'b1, guard <= 3)
        `CHK("held_new_sample", exp_pos(r, 1'b1), position_word)
        @(posedge clk);
        hold_request_n <= 1'b1;
        `WAIT_FOR(hold_ack == 1'b0)
    endtask : t_hold_marker

    task automatic t_selftest();
        reg_wr(ADDR_IRQ_MASK, 32'h8);
        @(posedge clk);
        test_fail <= 1'b1;
        cyc(3);
        `CHK("self_test_low", 1'b0, self_test_n)
        cyc(2);
        `CHK("irq_set", 1'b1, irq)
        reg_rd(ADDR_IRQ_STATUS);
        `CHK("status_fail", 1'b1, d[3])
        @(posedge clk);
        test_fail <= 1'b0;
        reg_wr(ADDR_IRQ_STATUS, 32'h8);
        reg_wr(ADDR_IRQ_MASK, 32'h0);
        cyc(3);
        `CHK("irq_clear", 1'b0, irq)
        `CHK("self_test_high", 1'b1, self_test_n)
        @(posedge clk);
        test_fail <= 1'b1;
        cyc(5);
        `CHK("irq_masked", 1'b0, irq)
        @(posedge clk);
        test_fail <= 1'b0;
    endtask : t_selftest

    task automatic t_serial(input logic fl, input logic ff, input logic [21:0] r);
        // Switch models only while the marker is low, so no pulse is cut short
        reg_rd(ADDR_CTRL);
        if (d[0] == 1'b0) begin
            `WAIT_FOR(update_marker)
            `WAIT_FOR(update_marker == 1'b0)
        end
        reg_wr(ADDR_CTRL, {30'h0, fl, 1'b1});
        @(posedge clk);
        test_fail <= ff;
        raw_angle <= r;
        nbits <= 5'(RES) + {4'h0, fl};
        hold_request_n <= 1'b0;
        acked = 1'b0;
        for (int i = 0; i < 800; i++) begin
            cyc(1);
            acked = acked | update_marker | hold_ack;
        end
        `CHK("no_parallel_handshake", 1'b0, acked)
        @(posedge clk);
        hold_request_n <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        `WAIT_FOR(ready)
        @(posedge clk);
        raw_angle <= ~r;
        cyc(2);
        `WAIT_FOR(busy == 1'b0)
        `CHK("ready_seen", 1'b0, timed_out)
        `CHK("serial_word", {2'b00, fl & ~ff, 20'(exp_pos(r, 1'b1) >> 2)}, host_word)
        `CHK("ready_after_last", 1'b0, ready)
        reg_rd(ADDR_IRQ_STATUS);
        `CHK("serial_done", 1'b1, d[2])
        reg_wr(ADDR_IRQ_STATUS, 32'hf);
    endtask : t_serial

    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence: parallel model first, then serial interrogations
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_marker(1'b1, 22'h2a5c3d);
        t_marker(1'b0, 22'h15a3c6);
        t_marker(1'b1, 22'h0c3f51);
        t_hold(22'h3e1287);
        t_hold_marker(22'h21b46a);
        t_selftest();
        t_serial(1'b1, 1'b0, 22'h1d2e3f);
        t_serial(1'b1, 1'b1, 22'h36a597);
        t_serial(1'b0, 1'b1, 22'h0a5a5c);
        report_and_stop();
    end
endmodule : tb_top
